// [verilog/hbt_front_end.sv]
// two-port hit front end: delay, bunch crossing assignment, masking,
// hit OR and triggered differential test pulse; wishbone configured
// assumes hit and trigger pins are asynchronous and are synchronised here
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module hbt_front_end
  import hbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // hit pins, one group per port
  input wire logic [CHANNELS-1:0] hitIn0,
  input wire logic [CHANNELS-1:0] hitIn1,
  output logic [CHANNELS-1:0] hitOut0,
  output logic [CHANNELS-1:0] hitOut1,
  output logic [PORTS-1:0] port_hit_or_output,
  // test pulse trigger pin and open-drain pulse legs
  input wire logic test_pulse_trigger_in,
  output logic [PORTS-1:0] tpPosOut,
  output logic [PORTS-1:0] tpPosOe_n,
  output logic [PORTS-1:0] tpNegOut,
  output logic [PORTS-1:0] tpNegOe_n,
  output logic [3:0] tpAmplitude0,
  output logic [3:0] tpAmplitude1
);
  // ==================================================================
  // helpers

  // delay code to cycles: code * (25 ns / units), rounded to clock cycles
  function automatic logic [TAP_BITS-1:0] codeToTap(
    input logic [4:0] code,
    input logic [1:0] ringSel
  );
    int units;
    int ps;
    int cyc;
    units = RING_BASE_UNITS + RING_UNIT_STEP * int'(ringSel);
    ps = (int'(code) * RING_LOOP_PS) / units;
    cyc = (ps + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    if (cyc > TAP_DEPTH - 1) begin
      cyc = TAP_DEPTH - 1;
    end
    return TAP_BITS'(cyc);
  endfunction

  // address to port index, or -1 when not a port block
  function automatic int portOf(input logic [7:0] adr);
    if (adr[7:4] == ADDR_PORT0[7:4]) begin
      return 0;
    end else if (adr[7:4] == ADDR_PORT1[7:4]) begin
      return 1;
    end else begin
      return -1;
    end
  endfunction

  // ==================================================================
  // configuration registers
  logic [1:0] ring_reg;
  logic [31:0] ctrl_reg [PORTS];
  logic [31:0] mask_reg [PORTS];
  logic [31:0] tp_reg [PORTS];
  logic wb_ack_next;
  logic [31:0] wb_dat_next;
  logic busWrite;
  logic [PORTS-1:0] tpBusy;
  logic [PORTS-1:0] coarseBusy;

  // a write lands at the edge where the master sees ack high
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // byte-lane merge of a write
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // register writes, taken on the acked cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ring_reg <= RING_RST;
      for (int p = 0; p < PORTS; p++) begin
        ctrl_reg[p] <= CTRL_RST;
        mask_reg[p] <= MASK_RST;
        tp_reg[p] <= TP_RST;
      end
    end else if (busWrite) begin
      if (wb_adr_i == ADDR_RING) begin
        if (wb_sel_i[0]) begin
          ring_reg <= wb_dat_i[1:0];
        end
      end else if (portOf(wb_adr_i) >= 0) begin
        for (int p = 0; p < PORTS; p++) begin
          if (portOf(wb_adr_i) == p) begin
            if (wb_adr_i[3:0] == OFF_CTRL) begin
              ctrl_reg[p] <= merge(ctrl_reg[p], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[3:0] == OFF_MASK) begin
              mask_reg[p] <= merge(mask_reg[p], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i[3:0] == OFF_TP) begin
              tp_reg[p] <= merge(tp_reg[p], wb_dat_i, wb_sel_i);
            end
          end
        end
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    wb_dat_next = '0;
    if (wb_adr_i == ADDR_RING) begin
      wb_dat_next[1:0] = ring_reg;
    end else if (wb_adr_i == ADDR_STATUS) begin
      wb_dat_next[1:0] = tpBusy;
      wb_dat_next[3:2] = coarseBusy;
      wb_dat_next[5:4] = port_hit_or_output;
    end else if (portOf(wb_adr_i) >= 0) begin
      for (int p = 0; p < PORTS; p++) begin
        if (portOf(wb_adr_i) == p) begin
          if (wb_adr_i[3:0] == OFF_CTRL) begin
            wb_dat_next = ctrl_reg[p] & 32'h0007_1f1f;
          end else if (wb_adr_i[3:0] == OFF_MASK) begin
            wb_dat_next = mask_reg[p] & 32'h0000_ffff;
          end else if (wb_adr_i[3:0] == OFF_TP) begin
            wb_dat_next = tp_reg[p] & 32'h001f_0f0f;
          end
        end
      end
    end
  end

  // one-cycle ack, one wait state after the request
  assign wb_ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_ack_next;
      wb_dat_o <= wb_ack_next ? wb_dat_next : '0;
    end
  end

  // ==================================================================
  // 40 MHz crossing enables from a fractional divider
  logic [7:0] bxAcc_reg;
  logic [7:0] bxAcc_next;
  logic bxRise;
  logic bxFall;

  always_comb begin
    bxAcc_next = bxAcc_reg + BX_ACC_ADD;
    bxRise = 1'b0;
    bxFall = 1'b0;
    if (bxAcc_next >= BX_ACC_MOD || bxAcc_next < bxAcc_reg) begin
      bxAcc_next = bxAcc_next - BX_ACC_MOD;
      bxRise = 1'b1;
    end else if (bxAcc_reg < BX_ACC_HALF && bxAcc_next >= BX_ACC_HALF) begin
      bxFall = 1'b1;
    end
  end

  // divider phase
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bxAcc_reg <= '0;
    end else begin
      bxAcc_reg <= bxAcc_next;
    end
  end

  // ==================================================================
  // trigger pin synchroniser, shared by both ports
  logic trigSync1_reg;
  logic trigSync2_reg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trigSync1_reg <= 1'b0;
      trigSync2_reg <= 1'b0;
    end else begin
      trigSync1_reg <= test_pulse_trigger_in;
      trigSync2_reg <= trigSync1_reg;
    end
  end

  // ==================================================================
  // per-port logic
  logic [CHANNELS-1:0] hitPin [PORTS];
  logic [CHANNELS-1:0] hitOutBus [PORTS];
  logic [3:0] ampBus [PORTS];

  assign hitPin[0] = hitIn0;
  assign hitPin[1] = hitIn1;
  assign hitOut0 = hitOutBus[0];
  assign hitOut1 = hitOutBus[1];
  assign tpAmplitude0 = ampBus[0];
  assign tpAmplitude1 = ampBus[1];

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [CHANNELS-1:0] hitSync1_reg;
    logic [CHANNELS-1:0] hitSync2_reg;
    logic [CHANNELS-1:0] hitPos;
    logic [CHANNELS-1:0] dly1Out;
    logic [CHANNELS-1:0] dly2Out;
    logic [CHANNELS-1:0] gateHit;
    logic [CHANNELS-1:0] gatePrev_reg;
    logic [CHANNELS-1:0] pending_reg;
    logic [CHANNELS-1:0] hitOut_reg;
    logic orOut_reg;
    logic polarity_select;
    logic bypass;
    logic [TAP_BITS-1:0] tap1;
    logic [TAP_BITS-1:0] tap2;
    logic [TAP_BITS-1:0] tapFine;
    logic trigSample_reg;
    logic trigCapture;
    logic [3:0] coarseCfg;
    hbt_tp_state_type tpState_reg;
    logic [3:0] coarseCnt_reg;
    logic [8:0] widthCnt_reg;
    logic launchReq;
    logic launch;

    assign polarity_select = ctrl_reg[p][CTRL_POL_BIT];
    assign bypass = ctrl_reg[p][CTRL_BYPASS_BIT];
    // one setting per port, shared by all channels
    assign tap1 = codeToTap(ctrl_reg[p][CTRL_DLY1_LSB +: 5], ring_reg);
    assign tap2 = codeToTap(ctrl_reg[p][CTRL_DLY2_LSB +: 5], ring_reg);
    assign tapFine = codeToTap(tp_reg[p][TP_FINE_LSB +: 5], ring_reg);

    // hit pin synchroniser
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        hitSync1_reg <= '0;
        hitSync2_reg <= '0;
      end else begin
        hitSync1_reg <= hitPin[p];
        hitSync2_reg <= hitSync1_reg;
      end
    end

    // polarity correction to positive logic
    assign hitPos = hitSync2_reg ^ {CHANNELS{polarity_select}};

    // first delay aligns hits to the crossing clock
    hbt_tap_delay #(.WIDTH(CHANNELS), .DEPTH(TAP_DEPTH)) u_dly1 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .dataIn(hitPos),
      .tap(tap1),
      .dataOut(dly1Out)
    );

    // second delay stretches the hit, widening the gate
    hbt_tap_delay #(.WIDTH(CHANNELS), .DEPTH(TAP_DEPTH)) u_dly2 (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .dataIn(dly1Out),
      .tap(tap2),
      .dataOut(dly2Out)
    );

    assign gateHit = dly1Out | dly2Out;

    // crossing assignment: hits seen since the last crossing edge
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        gatePrev_reg <= '0;
        pending_reg <= '0;
      end else begin
        gatePrev_reg <= gateHit;
        if (bxRise) begin
          pending_reg <= gateHit & ~gatePrev_reg;
        end else begin
          pending_reg <= pending_reg | (gateHit & ~gatePrev_reg);
        end
      end
    end

    // hit outputs: crossing pulse or straight-through route
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        hitOut_reg <= '0;
      end else if (bypass) begin
        hitOut_reg <= hitPos;
      end else if (bxRise) begin
        hitOut_reg <= pending_reg & mask_reg[p][CHANNELS-1:0];
      end else begin
        hitOut_reg <= '0;
      end
    end

    // raw hit OR, not crossing assigned
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        orOut_reg <= 1'b0;
      end else begin
        orOut_reg <= |hitPos;
      end
    end

    assign hitOutBus[p] = hitOut_reg;
    assign port_hit_or_output[p] = orOut_reg;

    // trigger sampling on the chosen crossing edge
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        trigSample_reg <= 1'b0;
      end else if (ctrl_reg[p][CTRL_TRIG_FALL_BIT] ? bxFall : bxRise) begin
        trigSample_reg <= trigSync2_reg;
      end
    end

    assign trigCapture = trigSync2_reg && !trigSample_reg &&
      (ctrl_reg[p][CTRL_TRIG_FALL_BIT] ? bxFall : bxRise);
    assign coarseCfg = (tp_reg[p][TP_COARSE_LSB +: 4] > 4'(COARSE_MAX)) ?
      4'(COARSE_MAX) : tp_reg[p][TP_COARSE_LSB +: 4];

    // coarse delay then fine delay then fixed-width pulse
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        tpState_reg <= TP_IDLE;
        coarseCnt_reg <= '0;
        widthCnt_reg <= '0;
      end else begin
        case (tpState_reg)
          TP_IDLE: begin
            if (trigCapture) begin
              coarseCnt_reg <= coarseCfg;
              if (coarseCfg != '0) begin
                tpState_reg <= TP_COARSE;
              end else if (launch) begin
                // fine tap 0 passes the request straight through
                widthCnt_reg <= 9'(PULSE_WIDTH_CYC - 1);
                tpState_reg <= TP_PULSE;
              end else begin
                tpState_reg <= TP_FINE;
              end
            end
          end
          TP_COARSE: begin
            if (bxRise) begin
              coarseCnt_reg <= coarseCnt_reg - 4'h1;
              if (coarseCnt_reg == 4'h1 && launch) begin
                widthCnt_reg <= 9'(PULSE_WIDTH_CYC - 1);
                tpState_reg <= TP_PULSE;
              end else if (coarseCnt_reg == 4'h1) begin
                tpState_reg <= TP_FINE;
              end
            end
          end
          TP_FINE: begin
            if (launch) begin
              widthCnt_reg <= 9'(PULSE_WIDTH_CYC - 1);
              tpState_reg <= TP_PULSE;
            end
          end
          TP_PULSE: begin
            if (widthCnt_reg == '0) begin
              tpState_reg <= TP_IDLE;
            end else begin
              widthCnt_reg <= widthCnt_reg - 9'h1;
            end
          end
          default: begin
            tpState_reg <= TP_IDLE;
          end
        endcase
      end
    end

    // one request into the fine delay at the coarse hand-off
    assign launchReq = (tpState_reg == TP_IDLE && trigCapture &&
      coarseCfg == '0) || (tpState_reg == TP_COARSE && bxRise &&
      coarseCnt_reg == 4'h1);

    hbt_tap_delay #(.WIDTH(1), .DEPTH(TAP_DEPTH)) u_fine (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .dataIn(launchReq),
      .tap(tapFine),
      .dataOut(launch)
    );

    assign tpBusy[p] = (tpState_reg == TP_PULSE);
    assign coarseBusy[p] = (tpState_reg == TP_COARSE);
    // open-drain legs: the active leg is pulled, the other released
    assign tpPosOut[p] = 1'b0;
    assign tpNegOut[p] = 1'b0;
    assign tpPosOe_n[p] = !(tpBusy[p] && !polarity_select);
    assign tpNegOe_n[p] = !(tpBusy[p] && polarity_select);
    assign ampBus[p] = tp_reg[p][TP_AMP_LSB +: 4];
  end
endmodule

// [verilog/hbt_pkg.sv]
// constants, register map and types for the hit delay, bunch crossing
// and test pulse block; assumes a 125 MHz reference clock
package hbt_pkg;
  // ==================================================================
  // structure
  localparam int PORTS = 2;
  localparam int CHANNELS = 16;
  localparam int TAP_DEPTH = 8;
  localparam int TAP_BITS = 3;
  // ==================================================================
  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RING_LOOP_NS = 25;
  localparam int RING_LOOP_PS = RING_LOOP_NS * 1000;
  localparam int RING_BASE_UNITS = 20;
  localparam int RING_UNIT_STEP = 4;
  localparam int MAX_CODE = 31;
  localparam int PULSE_WIDTH_US = 3;
  localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_US * 1000000) / CLK_PERIOD_PS;
  localparam int COARSE_MAX = 8;
  // 40 MHz crossing enables from a fractional divider: 80/250 of 125 MHz
  localparam logic [7:0] BX_ACC_ADD = 8'h50;
  localparam logic [7:0] BX_ACC_MOD = 8'hfa;
  localparam logic [7:0] BX_ACC_HALF = 8'h7d;
  // ==================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_RING = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PORT0 = 8'h10;
  localparam logic [7:0] ADDR_PORT1 = 8'h20;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_TP = 4'h8;
  // port control fields
  localparam int CTRL_DLY1_LSB = 0;
  localparam int CTRL_DLY2_LSB = 8;
  localparam int CTRL_POL_BIT = 16;
  localparam int CTRL_BYPASS_BIT = 17;
  localparam int CTRL_TRIG_FALL_BIT = 18;
  // test pulse fields
  localparam int TP_AMP_LSB = 0;
  localparam int TP_COARSE_LSB = 8;
  localparam int TP_FINE_LSB = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_ffff;
  localparam logic [31:0] TP_RST = 32'h0000_0000;
  localparam logic [1:0] RING_RST = 2'h3;

  typedef enum {TP_IDLE, TP_COARSE, TP_FINE, TP_PULSE} hbt_tp_state_type;
endpackage

// [verilog/hbt_tap_delay.sv]
// tapped delay line in whole clock cycles with a selectable tap
// assumes tap is static or changes rarely; tap 0 passes straight through
module hbt_tap_delay
  import hbt_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = TAP_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] dataIn,
  input wire logic [TAP_BITS-1:0] tap,
  output logic [WIDTH-1:0] dataOut
);
  // ==================================================================
  // shift stages
  logic [WIDTH-1:0] stage_reg [DEPTH];

  // shift one stage per clock
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= dataIn;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  // tap select
  always_comb begin
    if (tap == '0) begin
      dataOut = dataIn;
    end else begin
      dataOut = stage_reg[tap - 1'b1];
    end
  end
endmodule

// [bench/hbt_chk_assertions.sv]
// checker for hbt_front_end: bus answers, pulse legs, hit OR
// assumes it is bound to the top module and sees only its ports
module hbt_chk
  import hbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [CHANNELS-1:0] hitIn0,
  input wire logic [PORTS-1:0] port_hit_or_output,
  input wire logic [PORTS-1:0] tpPosOut,
  input wire logic [PORTS-1:0] tpPosOe_n,
  input wire logic [PORTS-1:0] tpNegOut,
  input wire logic [PORTS-1:0] tpNegOe_n,
  input wire logic [3:0] tpAmplitude0,
  input wire logic [3:0] tpAmplitude1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic pulseOn;
  logic [9:0] widthCnt_reg;
  // ==========================================
  // port 0 pulse length counter
  assign pulseOn = !(tpPosOe_n[0] && tpNegOe_n[0]);
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !pulseOn) begin
      widthCnt_reg <= '0;
    end else begin
      widthCnt_reg <= widthCnt_reg + 10'h1;
    end
  end
  // ==========================================
  // assertions
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_legs_apart: assert property (
    (tpPosOe_n | tpNegOe_n) == 2'h3)
    else $error("both pulse legs pulled");
  chk_drain_low: assert property (
    tpPosOut == 2'h0 && tpNegOut == 2'h0)
    else $error("open drain data not low");
  chk_pulse_width: assert property (
    $fell(pulseOn) |-> widthCnt_reg == PULSE_WIDTH_CYC)
    else $error("pulse width wrong");
  chk_pulse_bound: assert property (
    widthCnt_reg <= PULSE_WIDTH_CYC)
    else $error("pulse too long");
  chk_amp_by_write: assert property (
    $changed({tpAmplitude1, tpAmplitude0}) |->
      $past(wb_ack_o && wb_we_i))
    else $error("amplitude changed without write");
  chk_or_mixed: assert property (
    $past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n) &&
    (|$past(hitIn0, 3)) && !(&$past(hitIn0, 3))
      |-> port_hit_or_output[0])
    else $error("hit or missing");
  cover property (wb_ack_o && wb_we_i);
  cover property ($fell(pulseOn));
  cover property (port_hit_or_output[0]);
endmodule

// [bench/hbt_boards.sv]
// model of the two discriminator boards driving the hit pins
// assumes fire is called just after a rising clock edge
module hbt_boards
  import hbt_pkg::*;
(
  input wire logic ref_clk,
  output logic [CHANNELS-1:0] hitIn0,
  output logic [CHANNELS-1:0] hitIn1
);
  timeunit 1ns;
  timeprecision 1ps;
  // no-hit level is low on every channel
  initial begin
    hitIn0 = '0;
    hitIn1 = '0;
  end
  // raise a channel pattern on one board, hold it, release both boards
  task automatic fire(input int port, input logic [15:0] chans,
                      input int hold);
    if (port == 0) hitIn0 <= chans;
    else hitIn1 <= chans;
    repeat (hold) @(posedge ref_clk);
    hitIn0 <= '0;
    hitIn1 <= '0;
  endtask
endmodule

// [bench/test_hbt_front_end.sv]
// self-checking bench for hbt_front_end
// assumes the boards model and the bound checker beside it
module test_hbt_front_end
  import hbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, tpAmplitude0, tpAmplitude1;
  logic [31:0] wb_dat_i, wb_dat_o, seed, rdQ[$], hitQ[$], tpQ[$];
  logic [15:0] hitIn0, hitIn1, hitOut0, hitOut1;
  logic [1:0] port_hit_or_output, tpPosOut, tpPosOe_n, tpNegOut;
  logic [1:0] tpNegOe_n;
  logic test_pulse_trigger_in, hitWatch = 0, legIdle = 0;
  int miscompares = 0, n_tests = 0, cycles = 0, lat0, lat1;
  always #4 ref_clk = ~ref_clk;
  hbt_front_end i_dut (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .hitIn0, .hitIn1, .hitOut0, .hitOut1, .port_hit_or_output,
    .test_pulse_trigger_in, .tpPosOut, .tpPosOe_n, .tpNegOut,
    .tpNegOe_n, .tpAmplitude0, .tpAmplitude1);
  hbt_boards i_boards (.ref_clk, .hitIn0, .hitIn1);
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] padr(int p, logic [3:0] off);
    return (p != 0 ? ADDR_PORT1 : ADDR_PORT0) | {4'h0, off};
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pop(string nm, ref logic [31:0] q[$],
                     input logic [31:0] g);
    if (q.size() == 0) begin
      n_tests++;
      miscompares++;
      $display("[FAIL] %s expected none seen %h", nm, g);
    end else cmp(nm, q.pop_front(), g);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle; waits for ack, then idles a cycle
  task automatic bus(logic we, logic [7:0] a, logic [3:0] s,
                     logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rdQ.push_back(e);
    bus(0, a, 4'hf, rnd());
  endtask
  // fire port 0 hits, note expectation, measure latency
  task automatic hit(logic [15:0] c, logic [15:0] e, output int lat);
    int t0;
    t0 = cycles;
    lat = 0;
    if (e != 16'h0) hitQ.push_back({16'h0, e});
    fork
      i_boards.fire(0, c, 6);
    join_none
    repeat (40) begin
      @(posedge ref_clk);
      if (lat == 0 && hitOut0 != 16'h0) lat = cycles - t0;
    end
  endtask
  // ==========================================
  // watcher: compares results against the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      pop("read", rdQ, wb_dat_o);
    if (hitWatch && hitOut0 != 16'h0) pop("hit", hitQ, {16'h0, hitOut0});
    if (legIdle && (tpPosOe_n & tpNegOe_n) != 2'h3)
      pop("legs", tpQ, {28'h0, tpNegOe_n, tpPosOe_n});
    legIdle <= (tpPosOe_n & tpNegOe_n) == 2'h3;
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d, e, rstT[3], wmT[3];
    logic [3:0] offT[3], s;
    int c, n, lat;
    rstT = '{CTRL_RST, MASK_RST, TP_RST};
    wmT = '{32'h0007_1f1f, 32'h0000_ffff, 32'h001f_0f0f};
    offT = '{OFF_CTRL, OFF_MASK, OFF_TP};
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, test_pulse_trigger_in} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    seed = 32'h43a6495b;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    // reset values, read-only and unmapped places, merged writes
    rd(ADDR_RING, {30'h0, RING_RST});
    bus(1, ADDR_STATUS, 4'hf, rnd());
    rd(ADDR_STATUS, 32'h0);
    rd(8'h08, 32'h0);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        d = rnd();
        s = d[27:24];
        e = rstT[k];
        for (int b = 0; b < 4; b++) if (s[b]) e[8*b+:8] = d[8*b+:8];
        rd(padr(p, offT[k]), rstT[k]);
        bus(1, padr(p, offT[k]), s, d);
        rd(padr(p, offT[k]), e & wmT[k]);
        if (k == 2)
          cmp("amp", e[3:0], p ? tpAmplitude1 : tpAmplitude0);
      end
    end
    // masking, one pulse per hit, delay code effect
    bus(1, ADDR_RING, 4'hf, 32'h0);
    bus(1, padr(0, OFF_CTRL), 4'hf, 32'h0);
    d = rnd();
    bus(1, padr(0, OFF_MASK), 4'hf, d);
    hitWatch = 1;
    hit(d[31:16], d[31:16] & d[15:0], lat);
    bus(1, padr(0, OFF_MASK), 4'hf, 32'h0);
    hit(16'hffff, 16'h0, lat);
    bus(1, padr(0, OFF_MASK), 4'hf, 32'hffff);
    hit(16'h8001, 16'h8001, lat0);
    bus(1, padr(0, OFF_CTRL), 4'hf, 32'h1f1f);
    hit(16'h8001, 16'h8001, lat1);
    n = (31 * RING_LOOP_PS / 20 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    cmp("delay", 1, (lat1 - lat0 >= n - 4 && lat1 - lat0 <= n + 4));
    // route bypass and polarity inversion
    hitWatch = 0;
    bus(1, padr(0, OFF_CTRL), 4'hf, 32'h2_0000);
    bus(1, padr(1, OFF_CTRL), 4'hf, 32'h3_0000);
    d = rnd() | 32'h1;
    fork
      i_boards.fire(0, d[15:0], 8);
    join_none
    repeat (6) @(posedge ref_clk);
    cmp("bypass", d[15:0], hitOut0);
    cmp("invert", 16'hffff, hitOut1);
    cmp("hitor", 2'h3, port_hit_or_output);
    repeat (4) @(posedge ref_clk);
    // test pulses: coarse 0 with fine 0, coarse 8, clamped 15 on falling
    bus(1, ADDR_RING, 4'hf, 32'h3);
    foreach (offT[k]) begin
      c = (k == 0) ? 0 : (k == 1) ? 8 : 15;
      e = {11'h0, (k == 0) ? 5'h0 : 5'h1f, 4'h0, 4'(c), 4'h0, 4'(k + 5)};
      d = (k == 2) ? 32'h4_0000 : 32'h0;
      bus(1, padr(0, OFF_CTRL), 4'hf, d);
      bus(1, padr(1, OFF_CTRL), 4'hf, d | 32'h1_0000);
      bus(1, padr(0, OFF_TP), 4'hf, e);
      bus(1, padr(1, OFF_TP), 4'hf, e);
      cmp("amp", 4'(k + 5), tpAmplitude0);
      c = (c > COARSE_MAX) ? COARSE_MAX : c;
      tpQ.push_back(32'h6);
      test_pulse_trigger_in <= 1;
      lat = -1;
      n = cycles;
      repeat (600) begin
        @(posedge ref_clk);
        if (cycles - n == 20) test_pulse_trigger_in <= 0;
        if (lat < 0 && (tpPosOe_n & tpNegOe_n) != 2'h3) lat = cycles - n;
      end
      cmp("launch", 1, (lat >= 3 * c && lat <= 4 * c + 16));
    end
    cmp("left", 0, rdQ.size() + hitQ.size() + tpQ.size());
    wrap_up();
  end
endmodule
bind hbt_front_end hbt_chk i_chk (.ref_clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .hitIn0,
  .port_hit_or_output, .tpPosOut, .tpPosOe_n, .tpNegOut, .tpNegOe_n,
  .tpAmplitude0, .tpAmplitude1);
